/* File: nvm_status_irq_addr_regs.sv */
/*
 * Status, interrupt flag, target address and region protection registers of
 * a flash controller, reachable over Avalon-MM; reads wait one cycle, writes none.
 * Assumes the controller core gives one-cycle event pulses synchronous to clk_sys.
 */
module nvm_status_irq_addr_regs (
    input  wire logic                                clk_sys,
    input  wire logic                                rst_n,
    input  wire logic                                clkEn,
    input  wire logic [5:0]                          avsAddress,
    input  wire logic                                avsRead,
    input  wire logic                                avsWrite,
    input  wire logic [31:0]                         avsWriteData,
    input  wire logic [3:0]                          avsByteEnable,
    output logic [31:0]                              avsReadData,
    output logic                                     avsWaitRequest,
    output logic                                     irq,
    input  wire logic                                coreBusy,
    input  wire logic                                arrayFaultEvt,
    input  wire logic                                lockFaultEvt,
    input  wire logic                                badCmdEvt,
    input  wire logic                                pageLoadEvt,
    input  wire logic [nvmsr_pkg::TARGET_W-1:0]      pageLoadAddr,
    input  wire logic                                pageWriteCmd,
    input  wire logic                                bufferWipeCmd,
    input  wire logic                                enterPowerSavingCmd,
    input  wire logic                                exitPowerSavingCmd,
    input  wire logic                                arrayAccess,
    input  wire logic                                sleepEnter,
    input  wire logic                                sleepExit,
    input  wire logic                                securitySetEvt,
    input  wire logic                                debugChipErase,
    input  wire logic                                cfgRowLoad,
    input  wire logic [nvmsr_pkg::PROTECT_W-1:0]     cfgRowProtect,
    input  wire logic                                protectCmdWr,
    input  wire logic [nvmsr_pkg::PROTECT_W-1:0]     protectCmdValue,
    input  wire logic                                cfgRowErase,
    input  wire logic                                execKeyCmd,
    output logic [nvmsr_pkg::ARRAY_ADDR_W-1:0]       arrayAddr,
    output logic                                     arrayAddrValid
);
    import nvmsr_pkg::*;

    logic                    readyEn_reg;
    logic                    errorEn_reg;
    logic                    errorFlag_reg;
    logic [4:0]              stateFlags_reg;
    logic                    securityActive_reg;
    logic [TARGET_W-1:0]     target_reg;
    logic [PROTECT_W-1:0]    protect_reg;
    logic [1:0]              policy_reg;
    logic                    rdDone_reg;
    logic [31:0]             readMux;
    logic                    hitMapped;
    logic [4:0]              hwSet;
    logic [4:0]              hwClr;
    logic [4:0]              swClr;

    wire wrEn     = clkEn && avsWrite;
    wire lowByte  = avsByteEnable[0];
    wire wrSet    = wrEn && lowByte && (avsAddress == OFS_IRQ_SET);
    wire wrClrEn  = wrEn && lowByte && (avsAddress == OFS_IRQ_CLR);
    wire wrFlags  = wrEn && lowByte && (avsAddress == OFS_IRQ_FLAGS);
    wire wrState  = wrEn && lowByte && (avsAddress == OFS_CTRL_STATE);
    wire wrTarget = wrEn && (avsAddress == OFS_TARGET);
    wire wrPolicy = wrEn && lowByte && (avsAddress == OFS_POLICY);
    wire readyFlag  = ~coreBusy;
    wire anyFault   = arrayFaultEvt | lockFaultEvt | badCmdEvt;
    wire autoPolicy = (policy_reg != POL_DISABLED);
    wire psEnter    = enterPowerSavingCmd | (sleepEnter & autoPolicy);
    wire psExit     = exitPowerSavingCmd
                    | (arrayAccess & autoPolicy)
                    | (sleepExit & (policy_reg == POL_INSTANT));

    // Hardware sets, per status bit
    assign hwSet[BIT_PSAVE]  = psEnter;
    assign hwSet[BIT_LOAD]   = pageLoadEvt;
    assign hwSet[BIT_BADCMD] = badCmdEvt;
    assign hwSet[BIT_LOCKF]  = lockFaultEvt;
    assign hwSet[BIT_ARRAYF] = arrayFaultEvt;
    assign hwClr = {3'h0, pageWriteCmd | bufferWipeCmd, psExit & ~psEnter};
    // Power-saving bit is read-only: software cannot clear it
    assign swClr = wrState ? {avsWriteData[4:1], 1'b0} : 5'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    stateFlags_reg[gi] <= 1'b0;
                end else if (clkEn) begin
                    // Set wins over any clear
                    stateFlags_reg[gi] <= hwSet[gi] | (stateFlags_reg[gi] & ~hwClr[gi] & ~swClr[gi]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            readyEn_reg   <= 1'b0;
            errorEn_reg   <= 1'b0;
            errorFlag_reg <= 1'b0;
            policy_reg    <= POLICY_RST;
        end else if (clkEn) begin
            if (wrSet && avsWriteData[BIT_READY]) begin
                readyEn_reg <= 1'b1;
            end else if (wrClrEn && avsWriteData[BIT_READY]) begin
                readyEn_reg <= 1'b0;
            end
            if (wrSet && avsWriteData[BIT_ERROR]) begin
                errorEn_reg <= 1'b1;
            end else if (wrClrEn && avsWriteData[BIT_ERROR]) begin
                errorEn_reg <= 1'b0;
            end
            errorFlag_reg <= anyFault
                           | (errorFlag_reg & ~(wrFlags & avsWriteData[BIT_ERROR]));
            if (wrPolicy) begin
                policy_reg <= avsWriteData[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            securityActive_reg <= 1'b0;
        end else if (clkEn) begin
            if (securitySetEvt) begin
                securityActive_reg <= 1'b1;
            end else if (debugChipErase) begin
                securityActive_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            target_reg <= '0;
        end else if (clkEn) begin
            if (pageLoadEvt) begin
                target_reg <= pageLoadAddr;
            end else if (wrTarget) begin
                if (avsByteEnable[0]) target_reg[7:0]   <= avsWriteData[7:0];
                if (avsByteEnable[1]) target_reg[15:8]  <= avsWriteData[15:8];
                if (avsByteEnable[2]) target_reg[21:16] <= avsWriteData[21:16];
            end
        end
    end

    // Reset value comes from the configuration row once it is fetched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            protect_reg <= PROTECT_ERASED;
        end else if (clkEn) begin
            if (cfgRowErase) begin
                protect_reg <= PROTECT_ERASED;
            end else if (cfgRowLoad) begin
                protect_reg <= cfgRowProtect;
            end else if (protectCmdWr) begin
                protect_reg <= protectCmdValue;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arrayAddr      <= '0;
            arrayAddrValid <= 1'b0;
        end else if (clkEn) begin
            arrayAddrValid <= execKeyCmd;
            if (execKeyCmd) begin
                arrayAddr <= target_reg[ARRAY_ADDR_W-1:0];
            end
        end
    end

    always_comb begin
        hitMapped = 1'b1;
        case (avsAddress)
            OFS_IRQ_CLR,
            OFS_IRQ_SET:    readMux = {30'h0, errorEn_reg, readyEn_reg};
            OFS_IRQ_FLAGS:  readMux = {30'h0, errorFlag_reg, readyFlag};
            OFS_CTRL_STATE: readMux = {23'h0, securityActive_reg, 3'h0, stateFlags_reg};
            OFS_TARGET:     readMux = {10'h0, target_reg};
            OFS_PROTECT:    readMux = {16'h0, protect_reg};
            OFS_POLICY:     readMux = {30'h0, policy_reg};
            default: begin
                readMux   = 32'h0;
                hitMapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avsReadData <= 32'h0;
        end else if (clkEn && avsRead && !rdDone_reg) begin
            avsReadData <= hitMapped ? readMux : 32'h0;
        end
    end

    // Read answers a cycle late so its data comes from a flip-flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdDone_reg <= 1'b0;
        end else if (clkEn) begin
            rdDone_reg <= avsRead && !rdDone_reg;
        end
    end

    assign avsWaitRequest = avsRead && !rdDone_reg;
    assign irq = (readyEn_reg & readyFlag) | (errorEn_reg & errorFlag_reg);

    chk_error_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && anyFault |=> errorFlag_reg)
        else $error("error flag not set after fault");
    chk_load_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && pageLoadEvt |=> stateFlags_reg[BIT_LOAD])
        else $error("load flag not set");
    chk_load_wipe: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && bufferWipeCmd && !pageLoadEvt |=> !stateFlags_reg[BIT_LOAD])
        else $error("load flag survived wipe");
    chk_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrState && avsWriteData[BIT_LOCKF] && lockFaultEvt |=> stateFlags_reg[BIT_LOCKF])
        else $error("set lost to clear");
    chk_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && stateFlags_reg[BIT_ARRAYF] && wrState && !avsWriteData[BIT_ARRAYF]
        |=> stateFlags_reg[BIT_ARRAYF])
        else $error("zero write cleared flag");
    chk_secure_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        securityActive_reg && !debugChipErase |=> securityActive_reg)
        else $error("security bit dropped");
    chk_addr_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && execKeyCmd |=> arrayAddr == $past(target_reg[15:0]) && arrayAddrValid)
        else $error("array address wrong");
    chk_target_upd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && pageLoadEvt |=> target_reg == $past(pageLoadAddr))
        else $error("target not updated");
    chk_protect_erase: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && cfgRowErase |=> protect_reg == PROTECT_ERASED)
        else $error("protection not cleared");
    chk_ready_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrSet && avsWriteData[BIT_READY] |=> readyEn_reg)
        else $error("ready enable not set");
    chk_ps_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && enterPowerSavingCmd |=> stateFlags_reg[BIT_PSAVE])
        else $error("power saving not entered");

    // Bus handshake
    chk_rd_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && avsRead && avsWaitRequest |=> !avsWaitRequest)
        else $error("read answer late");
    chk_wr_nowait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        avsWrite |-> !avsWaitRequest)
        else $error("write stalled");
    chk_rd_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && avsRead && !avsWaitRequest |=> $stable(avsReadData))
        else $error("read data moved after answer");
    chk_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && avsRead && !rdDone_reg && !hitMapped |=> avsReadData == 32'h0)
        else $error("unmapped read not zero");
    chk_ready_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && avsRead && !rdDone_reg && avsAddress == OFS_IRQ_FLAGS |=> avsReadData[BIT_READY] == !$past(coreBusy))
        else $error("ready flag read wrong");

    // Flag sets and clears
    chk_error_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrFlags && avsWriteData[BIT_ERROR] && !anyFault |=> !errorFlag_reg)
        else $error("error flag not cleared");
    chk_error_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && errorFlag_reg && !(wrFlags && avsWriteData[BIT_ERROR]) |=> errorFlag_reg)
        else $error("error flag dropped");
    chk_arrayf_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && arrayFaultEvt |=> stateFlags_reg[BIT_ARRAYF])
        else $error("array fault bit not set");
    chk_lockf_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && lockFaultEvt |=> stateFlags_reg[BIT_LOCKF])
        else $error("protected write bit not set");
    chk_badcmd_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && badCmdEvt |=> stateFlags_reg[BIT_BADCMD])
        else $error("bad command bit not set");
    chk_status_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrState && avsWriteData[BIT_ARRAYF] && !arrayFaultEvt |=> !stateFlags_reg[BIT_ARRAYF])
        else $error("array fault bit not cleared");
    chk_lockf_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrState && avsWriteData[BIT_LOCKF] && !lockFaultEvt |=> !stateFlags_reg[BIT_LOCKF])
        else $error("protected write bit not cleared");
    chk_load_pgwr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && pageWriteCmd && !pageLoadEvt |=> !stateFlags_reg[BIT_LOAD])
        else $error("load flag survived page write");
    chk_load_sw: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrState && avsWriteData[BIT_LOAD] && !pageLoadEvt |=> !stateFlags_reg[BIT_LOAD])
        else $error("load flag survived clear");
    chk_en_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrSet && !avsWriteData[BIT_READY] |=> readyEn_reg == $past(readyEn_reg))
        else $error("zero write changed enable");
    chk_en_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrClrEn && avsWriteData[BIT_READY] |=> !readyEn_reg)
        else $error("ready enable not cleared");

    // Security, power saving, protection and address
    chk_secure_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && securitySetEvt |=> securityActive_reg)
        else $error("security bit not set");
    chk_secure_wipe: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && debugChipErase && !securitySetEvt |=> !securityActive_reg)
        else $error("security bit survived erase");
    chk_ps_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && exitPowerSavingCmd && !psEnter |=> !stateFlags_reg[BIT_PSAVE])
        else $error("power saving not left");
    chk_ps_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && sleepEnter && policy_reg != POL_DISABLED |=> stateFlags_reg[BIT_PSAVE])
        else $error("sleep did not enter power saving");
    chk_ps_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && stateFlags_reg[BIT_PSAVE] && !psExit |=> stateFlags_reg[BIT_PSAVE])
        else $error("power saving bit dropped");
    chk_protect_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && cfgRowLoad && !cfgRowErase |=> protect_reg == $past(cfgRowProtect))
        else $error("protection not loaded");
    chk_protect_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && protectCmdWr && !cfgRowLoad && !cfgRowErase |=> protect_reg == $past(protectCmdValue))
        else $error("protection command lost");
    chk_protect_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(clkEn && (cfgRowErase || cfgRowLoad || protectCmdWr)) |=> $stable(protect_reg))
        else $error("protection changed without command");
    chk_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && !execKeyCmd |=> !arrayAddrValid)
        else $error("array address valid without execute");
    chk_target_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrTarget && !pageLoadEvt && avsByteEnable[0] |=> target_reg[7:0] == $past(avsWriteData[7:0]))
        else $error("target write lost");
    chk_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clkEn |=> $stable(stateFlags_reg) && $stable(errorFlag_reg) && $stable(target_reg))
        else $error("state moved while frozen");

    cov_error_irq: cover property (@(posedge clk_sys) disable iff (!rst_n)
        anyFault ##1 errorFlag_reg ##[1:20] !errorFlag_reg);
    cov_ps_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
        stateFlags_reg[BIT_PSAVE] ##[1:20] !stateFlags_reg[BIT_PSAVE]);
    cov_exec: cover property (@(posedge clk_sys) disable iff (!rst_n)
        pageLoadEvt ##[1:20] execKeyCmd);
    cov_set_wins: cover property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && wrState && avsWriteData[BIT_LOCKF] && lockFaultEvt);
    cov_rd_wait: cover property (@(posedge clk_sys) disable iff (!rst_n)
        avsRead && avsWaitRequest ##1 avsRead && !avsWaitRequest);
endmodule : nvm_status_irq_addr_regs

/* File: nvmsr_pkg.sv */
/*
 * Package for the flash controller status, interrupt and address registers:
 * register offsets, field positions, reset values and policy encodings.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and one clock domain.
 */
// Operation
// - Writing one to enable-set bit 0 enables ready interrupt; zero ignored; reads state.
// - Error flag bit 1 sets on array, locked-region or bad-command fault; write-one clears.
// - Ready flag bit 0 reads zero while busy, one when ready for commands.
// - Status bit 8 shows security active; only debugger chip erase clears it.
// - Status bit 4 sets on program or erase failure; write-one clears.
// - Status bit 3 sets on programming a protected region; write-one clears.
// - Status bit 2 sets on undefined command or wrong key; write-one clears.
// - Status bit 1 sets on page buffer load; cleared by page write, wipe, or write-one.
// - Status bit 0 shows power saving, entered by command or sleep per policy.
// - Power saving ends on array access, commands, or sleep exit per policy.
// - 22-bit target address register drives 16-bit array address on keyed execute.
// - Target address updates itself on every page buffer write.
// - Region-protection register is read-only, reset value loaded from configuration row.
// - Protection bit reads zero when region protected, one when unprotected.
// - Protection bits change only by commands; configuration erase makes them all one.
package nvmsr_pkg;
    localparam logic [5:0]  OFS_IRQ_CLR    = 6'h0C;
    localparam logic [5:0]  OFS_IRQ_SET    = 6'h10;
    localparam logic [5:0]  OFS_IRQ_FLAGS  = 6'h14;
    localparam logic [5:0]  OFS_CTRL_STATE = 6'h18;
    localparam logic [5:0]  OFS_TARGET     = 6'h1C;
    localparam logic [5:0]  OFS_PROTECT    = 6'h20;
    localparam logic [5:0]  OFS_POLICY     = 6'h24;
    localparam int          BIT_READY      = 0;
    localparam int          BIT_ERROR      = 1;
    localparam int          BIT_PSAVE      = 0;
    localparam int          BIT_LOAD       = 1;
    localparam int          BIT_BADCMD     = 2;
    localparam int          BIT_LOCKF      = 3;
    localparam int          BIT_ARRAYF     = 4;
    localparam int          BIT_SECURE     = 8;
    localparam int          TARGET_W       = 22;
    localparam int          ARRAY_ADDR_W   = 16;
    localparam int          PROTECT_W      = 16;
    localparam logic [15:0] PROTECT_ERASED = 16'hFFFF;
    localparam logic [1:0]  POLICY_RST     = 2'h0;
    localparam logic [1:0]  POL_ON_ACCESS  = 2'h0;
    localparam logic [1:0]  POL_INSTANT    = 2'h1;
    localparam logic [1:0]  POL_DISABLED   = 2'h3;
endpackage : nvmsr_pkg

/* File: nvm_status_irq_addr_regs_test.sv */
/*
 * Self-checking bench for the flash controller status, flag and address registers.
 * Assumes nvmsr_pkg is compiled first; every access waits on avsWaitRequest.
 */
module nvm_status_irq_addr_regs_test;
    import nvmsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, rst_n = 0, coreBusy = 0, clkEn = 1;
    logic [5:0]  avsAddress = '0;
    logic        avsRead = 0, avsWrite = 0;
    logic [31:0] avsWriteData = '0, avsReadData, rnd = 32'h07C28DC8, rdv;
    logic        avsWaitRequest, irq, arrayAddrValid;
    logic [16:0] ev = '0;
    logic [21:0] ldAddr = '0;
    logic [15:0] cfgVal = '0, cmdVal = '0, arrayAddr;
    int          errors = 0, cmp_count = 0, tgt = 0;
    always #2.5 clk_sys = ~clk_sys;
    nvm_status_irq_addr_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .irq(irq), .coreBusy(coreBusy),
        .arrayFaultEvt(ev[0]), .lockFaultEvt(ev[1]), .badCmdEvt(ev[2]), .pageLoadEvt(ev[3]),
        .pageLoadAddr(ldAddr), .pageWriteCmd(ev[4]), .bufferWipeCmd(ev[5]), .enterPowerSavingCmd(ev[6]),
        .exitPowerSavingCmd(ev[7]), .arrayAccess(ev[8]), .sleepEnter(ev[9]), .sleepExit(ev[10]),
        .securitySetEvt(ev[11]), .debugChipErase(ev[12]), .cfgRowLoad(ev[13]), .cfgRowProtect(cfgVal),
        .protectCmdWr(ev[14]), .protectCmdValue(cmdVal), .cfgRowErase(ev[15]), .execKeyCmd(ev[16]),
        .arrayAddr(arrayAddr), .arrayAddrValid(arrayAddrValid));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= 1'b1;
        do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
        avsWrite <= 1'b0;
        // Events raised with a write last only until it is taken
        ev <= '0;
        @(posedge clk_sys);
    endtask : wr
    // Read data taken at the edge that ends the wait
    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
        rdv = avsReadData;
        avsRead <= 1'b0;
        @(posedge clk_sys);
        chk($sformatf("reg_%0h", a), rdv, exp);
    endtask : rchk
    task automatic pulse(input int n);
        ev[n] <= 1'b1;
        @(posedge clk_sys);
        ev[n] <= 1'b0;
        @(posedge clk_sys);
    endtask : pulse
    task automatic close_out;
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rchk(OFS_IRQ_FLAGS, 32'h1);
        rchk(OFS_TARGET, 32'h0);
        rchk(OFS_PROTECT, 32'hFFFF);
        rchk(6'h3C, 32'h0);
        wr(OFS_IRQ_SET, 32'h0);
        rchk(OFS_IRQ_SET, 32'h0);
        wr(OFS_IRQ_SET, 32'h1);
        rchk(OFS_IRQ_SET, 32'h1);
        #1 chk("irq", irq, 1'b1);
        coreBusy <= 1'b1;
        @(posedge clk_sys);
        #1 chk("irq", irq, 1'b0);
        rchk(OFS_IRQ_FLAGS, 32'h0);
        wr(OFS_IRQ_SET, 32'h2);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            #1 chk("irq", irq, 1'b1);
            rchk(OFS_CTRL_STATE, 32'h1 << (4 - i));
            rchk(OFS_IRQ_FLAGS, 32'h2);
            wr(OFS_CTRL_STATE, 32'h0);
            wr(OFS_IRQ_FLAGS, 32'h0);
            rchk(OFS_CTRL_STATE, 32'h1 << (4 - i));
            wr(OFS_CTRL_STATE, 32'h1 << (4 - i));
            wr(OFS_IRQ_FLAGS, 32'h3);
            rchk(OFS_CTRL_STATE, 32'h0);
            rchk(OFS_IRQ_FLAGS, 32'h0);
        end
        ev[1] <= 1'b1;
        wr(OFS_CTRL_STATE, 32'h8);
        rchk(OFS_CTRL_STATE, 32'h8);
        wr(OFS_CTRL_STATE, 32'h8);
        wr(OFS_IRQ_FLAGS, 32'h2);
        wr(OFS_IRQ_CLR, 32'h3);
        rchk(OFS_IRQ_CLR, 32'h0);
        for (int i = 4; i < 7; i++) begin
            rnd = lfsr(rnd);
            ldAddr <= rnd[21:0];
            pulse(3);
            rchk(OFS_TARGET, {10'h0, rnd[21:0]});
            rchk(OFS_CTRL_STATE, 32'h2);
            if (i < 6) pulse(i);
            else wr(OFS_CTRL_STATE, 32'h2);
            rchk(OFS_CTRL_STATE, 32'h0);
        end
        rnd = lfsr(rnd);
        tgt = rnd & 32'h3FFFFF;
        wr(OFS_TARGET, rnd);
        rchk(OFS_TARGET, tgt);
        ev[16] <= 1'b1;
        @(posedge clk_sys);
        ev[16] <= 1'b0;
        #1 chk("valid", arrayAddrValid, 1'b1);
        chk("arrayAddr", arrayAddr, tgt & 32'hFFFF);
        @(posedge clk_sys);
        pulse(6);
        rchk(OFS_CTRL_STATE, 32'h1);
        pulse(8);
        rchk(OFS_CTRL_STATE, 32'h0);
        pulse(9);
        pulse(10);
        rchk(OFS_CTRL_STATE, 32'h1);
        wr(OFS_CTRL_STATE, 32'h1);
        rchk(OFS_CTRL_STATE, 32'h1);
        pulse(7);
        rchk(OFS_CTRL_STATE, 32'h0);
        wr(OFS_POLICY, {30'h0, POL_INSTANT});
        pulse(9);
        rchk(OFS_CTRL_STATE, 32'h1);
        pulse(10);
        rchk(OFS_CTRL_STATE, 32'h0);
        wr(OFS_POLICY, {30'h0, POL_DISABLED});
        pulse(9);
        rchk(OFS_CTRL_STATE, 32'h0);
        pulse(6);
        pulse(8);
        rchk(OFS_CTRL_STATE, 32'h1);
        pulse(7);
        rchk(OFS_CTRL_STATE, 32'h0);
        pulse(11);
        wr(OFS_CTRL_STATE, 32'h100);
        rchk(OFS_CTRL_STATE, 32'h100);
        pulse(12);
        rchk(OFS_CTRL_STATE, 32'h0);
        clkEn <= 1'b0;
        pulse(0);
        clkEn <= 1'b1;
        rchk(OFS_CTRL_STATE, 32'h0);
        rchk(OFS_IRQ_FLAGS, 32'h0);
        rnd = lfsr(rnd);
        cfgVal <= rnd[15:0];
        cmdVal <= rnd[31:16];
        pulse(13);
        wr(OFS_PROTECT, ~rnd);
        rchk(OFS_PROTECT, rnd & 32'hFFFF);
        pulse(14);
        rchk(OFS_PROTECT, rnd >> 16);
        pulse(15);
        rchk(OFS_PROTECT, 32'hFFFF);
        close_out();
    end
endmodule : nvm_status_irq_addr_regs_test
